// file: design/pmc_params.svh
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define PMC_IDX_PWR 8'h87
`define PMC_IDX_CLK 8'hD8
`define PMC_IDX_AUX 8'hF7
`define PMC_IDX_STAT 8'h40
`define PMC_IDX_FLAG 8'h41
`define PMC_IDX_ENA 8'h42
`define PMC_ADDR_LSB 2
`define PMC_ADDR_W 10

// Reset values.
`define PMC_RST_PWR 8'h00
`define PMC_RST_CLK 8'h23
`define PMC_RST_AUX 8'h06
`define PMC_RST_ENA 8'h00

// Writable masks.
`define PMC_MASK_PWR 8'h8F
`define PMC_MASK_AUX 8'hF7

// Power mode control fields.
`define PMC_PWR_IDLE 0
`define PMC_PWR_PDN 1

// Clock source control fields.
`define PMC_CLK_SLOWTYPE 7
`define PMC_CLK_FASTTYPE 6
`define PMC_CLK_SLOWSTOP 5
`define PMC_CLK_PERSTOP 4
`define PMC_CLK_FASTSTOP 3
`define PMC_CLK_FASTSEL 2
`define PMC_CLK_DIV_HI 1
`define PMC_CLK_DIV_LO 0

// Divider codes and the cycle counts they select.
`define PMC_DIV_16 2'h0
`define PMC_DIV_4 2'h1
`define PMC_DIV_2 2'h2
`define PMC_DIV_1 2'h3
`define PMC_CNT_16 4'hF
`define PMC_CNT_4 4'h3
`define PMC_CNT_2 4'h1
`define PMC_CNT_1 4'h0

// Flag layout: ext pins 2..0, pin change 3, tick 4; enable layout: ext pins 2..0, tick 3, port1 pins 7..4.
`define PMC_NUM_EXT 3
`define PMC_NUM_P1 4
`define PMC_BIT_P1 3
`define PMC_BIT_TICK 4
`define PMC_ENA_TICK 3
`define PMC_NUM_FLAG 5
`define PMC_ENA_P1_LO 4

// AXI responses.
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2

`endif

// file: design/pmc_pkg.sv
package pmc_pkg;

    // Operating mode; fast and slow running share the run state.
    typedef enum logic [1:0] {
        PMC_RUN = 2'b00,
        PMC_IDLE = 2'b01,
        PMC_HALT = 2'b10,
        PMC_STOP = 2'b11
    } pmc_mode_e;

    // Clock gate enables handed to the clock tree.
    typedef struct packed {
        logic cpu;
        logic periph;
        logic tick;
        logic wdt;
        logic fast_osc;
        logic slow_osc;
    } pmc_gates_s;

    // Oscillator selection handed to the clock mux.
    typedef struct packed {
        logic fast_sel;
        logic fast_xtal;
        logic slow_xtal;
    } pmc_osc_s;

endpackage

// file: design/pmc_top.sv
`include "pmc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pmc_top (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rstn,
    // AXI4-Lite write address and data.
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [`PMC_ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response.
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read.
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [`PMC_ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Wake and interrupt sources.
    input wire logic [`PMC_NUM_EXT-1:0] i_ext_irq_pin,
    input wire logic [`PMC_NUM_P1-1:0] i_port1_pin,
    input wire logic i_tick_irq,
    input wire logic i_other_irq,
    input wire logic i_wdt_en,
    // Clock control outputs.
    output pmc_pkg::pmc_gates_s o_gates,
    output pmc_pkg::pmc_osc_s o_osc,
    output logic o_sys_clk_en,
    output pmc_pkg::pmc_mode_e o_mode
);
    import pmc_pkg::*;

    localparam int NPIN = `PMC_NUM_EXT + `PMC_NUM_P1;

    // ********************
    // Pin synchronisers
    // ********************

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_reg;
    logic [NPIN-1:0] s2_reg;
    logic [NPIN-1:0] s3_reg;
    logic [NPIN-1:0] pin_reg;
    logic [NPIN-1:0] pin_prev_reg;

    assign pin_raw = {i_port1_pin, i_ext_irq_pin};

    // A level counts only once the second and third stages agree,
    // which also rejects a single-cycle glitch.
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge i_clk) begin
                if (!i_rstn) begin
                    s1_reg[g] <= 1'b1;
                    s2_reg[g] <= 1'b1;
                    s3_reg[g] <= 1'b1;
                    pin_reg[g] <= 1'b1;
                    pin_prev_reg[g] <= 1'b1;
                end else begin
                    s1_reg[g] <= pin_raw[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    if (s2_reg[g] == s3_reg[g]) begin
                        pin_reg[g] <= s3_reg[g];
                    end
                    pin_prev_reg[g] <= pin_reg[g];
                end
            end
        end
    endgenerate

    // ********************
    // Registers and events
    // ********************

    logic [7:0] pwr_reg;
    logic [7:0] clk_reg;
    logic [7:0] aux_reg;
    logic [7:0] ena_reg;
    logic [`PMC_NUM_FLAG-1:0] flag_reg;
    logic [`PMC_NUM_FLAG-1:0] flag_set;
    logic [`PMC_NUM_EXT-1:0] ext_fall;
    logic [`PMC_NUM_P1-1:0] p1_chg;
    logic [`PMC_NUM_EXT-1:0] ext_en;
    logic [`PMC_NUM_P1-1:0] p1_en;
    logic ext_low_armed;
    logic pin_wake;
    logic tick_wake;
    logic any_wake;
    pmc_mode_e mode_reg;

    assign ext_en = ena_reg[`PMC_NUM_EXT-1:0];
    assign p1_en = ena_reg[`PMC_ENA_P1_LO+`PMC_NUM_P1-1:`PMC_ENA_P1_LO];
    assign ext_fall = pin_prev_reg[`PMC_NUM_EXT-1:0]
                    & ~pin_reg[`PMC_NUM_EXT-1:0];
    assign p1_chg = pin_prev_reg[NPIN-1:`PMC_NUM_EXT]
                  ^ pin_reg[NPIN-1:`PMC_NUM_EXT];

    // Flags are set by the event alone, never by its enable.
    assign flag_set = {i_tick_irq, |p1_chg, ext_fall};

    // An enabled ext pin held low blocks Halt and Stop entry.
    assign ext_low_armed = |(ext_en & ~pin_reg[`PMC_NUM_EXT-1:0]);

    // Pin wake sources: three ext pins and four port1 bits.
    assign pin_wake = |(flag_reg[`PMC_NUM_EXT-1:0] & ext_en)
                    | (flag_reg[`PMC_BIT_P1] & |p1_en);
    assign tick_wake = flag_reg[`PMC_BIT_TICK] & ena_reg[`PMC_ENA_TICK];
    assign any_wake = pin_wake | tick_wake | i_other_irq;

    // ********************
    // AXI4-Lite slave
    // ********************

    logic aw_hold_reg;
    logic w_hold_reg;
    logic [`PMC_ADDR_W-1:0] awaddr_reg;
    logic [7:0] wbyte_reg;
    logic wlane_reg;
    logic wr_go;
    logic [7:0] wr_idx;
    logic wr_hit;
    logic [7:0] rd_idx;
    logic [7:0] rd_val;
    logic rd_hit;

    // A write is done once address and data are both held and
    // the previous response has been taken.
    assign wr_go = aw_hold_reg & w_hold_reg & ~o_bvalid;
    assign wr_idx = awaddr_reg[`PMC_ADDR_W-1:`PMC_ADDR_LSB];
    assign rd_idx = i_araddr[`PMC_ADDR_W-1:`PMC_ADDR_LSB];

    // Address and data channels are taken independently.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= '0;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= i_awaddr;
            end else if (wr_go) begin
                aw_hold_reg <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_hold_reg <= 1'b1;
                wbyte_reg <= i_wdata[7:0];
                wlane_reg <= i_wstrb[0];
            end else if (wr_go) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    // Ready is offered only while the holding slot is empty.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
        end else begin
            o_awready <= ~(aw_hold_reg | (i_awvalid & o_awready)) | wr_go;
            o_wready <= ~(w_hold_reg | (i_wvalid & o_wready)) | wr_go;
        end
    end

    always_comb begin
        unique case (wr_idx)
            `PMC_IDX_PWR, `PMC_IDX_CLK, `PMC_IDX_AUX,
            `PMC_IDX_STAT, `PMC_IDX_FLAG, `PMC_IDX_ENA: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write response; an unmapped address answers SLVERR.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_bvalid <= 1'b0;
            o_bresp <= `PMC_RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // Read mux; bits above the low byte read as zero.
    always_comb begin
        rd_hit = 1'b1;
        unique case (rd_idx)
            `PMC_IDX_PWR: rd_val = pwr_reg;
            `PMC_IDX_CLK: rd_val = clk_reg;
            `PMC_IDX_AUX: rd_val = aux_reg;
            `PMC_IDX_STAT: rd_val = {5'h00, ext_low_armed, mode_reg};
            `PMC_IDX_FLAG: rd_val = {3'h0, flag_reg};
            `PMC_IDX_ENA: rd_val = ena_reg;
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `PMC_RESP_OKAY;
        end else begin
            o_arready <= ~o_rvalid & ~(i_arvalid & o_arready);
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rdata <= {24'h00_0000, rd_val};
                o_rresp <= rd_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // ********************
    // Control registers
    // ********************

    logic wr_byte;
    logic fast_sel_now;
    logic fast_stop_now;
    logic [7:0] clk_next;
    logic pd_ok;
    logic leave;

    assign wr_byte = wr_go & wlane_reg;
    assign fast_sel_now = clk_reg[`PMC_CLK_FASTSEL];
    assign fast_stop_now = clk_reg[`PMC_CLK_FASTSTOP];
    assign pd_ok = ~ext_low_armed;

    // Guarded bits keep their old value when the write is illegal.
    always_comb begin
        clk_next = clk_reg;
        clk_next[`PMC_CLK_SLOWSTOP] = wbyte_reg[`PMC_CLK_SLOWSTOP];
        clk_next[`PMC_CLK_PERSTOP] = wbyte_reg[`PMC_CLK_PERSTOP];
        clk_next[`PMC_CLK_DIV_HI:`PMC_CLK_DIV_LO] =
            wbyte_reg[`PMC_CLK_DIV_HI:`PMC_CLK_DIV_LO];
        if (fast_sel_now) begin
            clk_next[`PMC_CLK_SLOWTYPE] = wbyte_reg[`PMC_CLK_SLOWTYPE];
        end
        if (!fast_sel_now) begin
            clk_next[`PMC_CLK_FASTTYPE] = wbyte_reg[`PMC_CLK_FASTTYPE];
            clk_next[`PMC_CLK_FASTSTOP] = wbyte_reg[`PMC_CLK_FASTSTOP];
        end
        // Selecting the fast clock in the same write that stops it
        // would leave the system without a clock, so it is dropped.
        if (!fast_stop_now && !clk_next[`PMC_CLK_FASTSTOP]) begin
            clk_next[`PMC_CLK_FASTSEL] = wbyte_reg[`PMC_CLK_FASTSEL];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            clk_reg <= `PMC_RST_CLK;
        end else if (wr_byte && wr_idx == `PMC_IDX_CLK) begin
            clk_reg <= clk_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            aux_reg <= `PMC_RST_AUX;
            ena_reg <= `PMC_RST_ENA;
        end else if (wr_byte) begin
            if (wr_idx == `PMC_IDX_AUX) begin
                aux_reg <= wbyte_reg & `PMC_MASK_AUX;
            end
            if (wr_idx == `PMC_IDX_ENA) begin
                ena_reg <= wbyte_reg;
            end
        end
    end

    // Flags clear by writing one; a new event in the same cycle wins.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            flag_reg <= '0;
        end else if (wr_byte && wr_idx == `PMC_IDX_FLAG) begin
            flag_reg <= (flag_reg & ~wbyte_reg[`PMC_NUM_FLAG-1:0])
                      | flag_set;
        end else begin
            flag_reg <= flag_reg | flag_set;
        end
    end

    // ********************
    // Mode machine
    // ********************

    // Wake-up from the current sleep state.
    always_comb begin
        unique case (mode_reg)
            PMC_IDLE: leave = any_wake;
            PMC_HALT: leave = pin_wake | tick_wake;
            PMC_STOP: leave = pin_wake;
            PMC_RUN: leave = 1'b0;
        endcase
    end

    // The request bits are cleared by hardware on wake-up; the
    // clock register is untouched, so the old selection returns.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pwr_reg <= `PMC_RST_PWR;
        end else if (leave) begin
            pwr_reg[`PMC_PWR_IDLE] <= 1'b0;
            pwr_reg[`PMC_PWR_PDN] <= 1'b0;
        end else if (wr_byte && wr_idx == `PMC_IDX_PWR) begin
            pwr_reg <= wbyte_reg & `PMC_MASK_PWR;
            if (!pd_ok) begin
                pwr_reg[`PMC_PWR_PDN] <= 1'b0;
            end
        end
    end

    // Power-down has priority over idle when both are set.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mode_reg <= PMC_RUN;
        end else begin
            unique case (mode_reg)
                PMC_RUN: begin
                    if (pwr_reg[`PMC_PWR_PDN]) begin
                        mode_reg <= clk_reg[`PMC_CLK_SLOWSTOP]
                                  ? PMC_STOP
                                  : PMC_HALT;
                    end else if (pwr_reg[`PMC_PWR_IDLE]) begin
                        mode_reg <= PMC_IDLE;
                    end
                end
                PMC_IDLE, PMC_HALT, PMC_STOP: begin
                    if (leave) begin
                        mode_reg <= PMC_RUN;
                    end
                end
            endcase
        end
    end

    // ********************
    // Clock gates and oscillator selection
    // ********************

    logic run;
    logic idle;

    assign run = mode_reg == PMC_RUN;
    assign idle = mode_reg == PMC_IDLE;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_gates <= '{cpu: 1'b1, periph: 1'b1, tick: 1'b1,
                         wdt: 1'b1, fast_osc: 1'b1, slow_osc: 1'b1};
            o_osc <= '0;
            o_mode <= PMC_RUN;
        end else begin
            o_gates.cpu <= run;
            o_gates.periph <= run
                            | (idle & ~clk_reg[`PMC_CLK_PERSTOP]);
            o_gates.tick <= run | idle
                          | (mode_reg == PMC_HALT
                             & ena_reg[`PMC_ENA_TICK]);
            o_gates.wdt <= run | idle | i_wdt_en;
            o_gates.fast_osc <= (fast_sel_now | ~fast_stop_now)
                              & (run | idle);
            o_gates.slow_osc <= mode_reg != PMC_STOP;
            o_osc.fast_sel <= fast_sel_now;
            o_osc.fast_xtal <= clk_reg[`PMC_CLK_FASTTYPE];
            o_osc.slow_xtal <= clk_reg[`PMC_CLK_SLOWTYPE];
            o_mode <= mode_reg;
        end
    end

    // ********************
    // System clock divider
    // ********************

    logic [3:0] div_cnt_reg;
    logic [3:0] div_top_reg;
    logic [3:0] div_top_next;

    always_comb begin
        unique case (clk_reg[`PMC_CLK_DIV_HI:`PMC_CLK_DIV_LO])
            `PMC_DIV_16: div_top_next = `PMC_CNT_16;
            `PMC_DIV_4: div_top_next = `PMC_CNT_4;
            `PMC_DIV_2: div_top_next = `PMC_CNT_2;
            `PMC_DIV_1: div_top_next = `PMC_CNT_1;
        endcase
    end

    // The new ratio is loaded only at the wrap of the count, so the
    // enable never shows a runt period; the longest wait is 16 cycles.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            div_cnt_reg <= 4'h0;
            div_top_reg <= `PMC_CNT_1;
            o_sys_clk_en <= 1'b0;
        end else if (div_cnt_reg >= div_top_reg) begin
            div_cnt_reg <= 4'h0;
            div_top_reg <= div_top_next;
            o_sys_clk_en <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
            o_sys_clk_en <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: test/pmc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Checker on the clock control and bus response ports
// ****************************************
module pmc_top_sva
    import pmc_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rstn,
    // Bus answers and their acceptance.
    input wire logic i_bready,
    input wire logic i_rready,
    input wire logic o_bvalid,
    input wire logic [1:0] o_bresp,
    input wire logic o_rvalid,
    input wire logic [31:0] o_rdata,
    // Clock control outputs.
    input wire pmc_pkg::pmc_gates_s o_gates,
    input wire pmc_pkg::pmc_osc_s o_osc,
    input wire logic o_sys_clk_en,
    input wire pmc_pkg::pmc_mode_e o_mode
);
    // Gates and mode come from one register stage.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    a_idle_gating: assert property (
        o_mode == PMC_IDLE |-> !o_gates.cpu && o_gates.tick)
        else $error("cpu clock not gated in idle");
    a_run_clocks: assert property (
        o_mode == PMC_RUN |-> o_gates.cpu && o_gates.periph)
        else $error("cpu or peripheral clock off while running");
    a_halt_gating: assert property (
        o_mode == PMC_HALT |-> !o_gates.cpu && !o_gates.periph
            && !o_gates.fast_osc)
        else $error("clock left running in halt");
    a_stop_gating: assert property (
        o_mode == PMC_STOP |-> !o_gates.cpu && !o_gates.periph
            && !o_gates.tick && !o_gates.fast_osc && !o_gates.slow_osc)
        else $error("clock left running in stop");
    a_fast_osc_on: assert property (
        o_mode == PMC_RUN && o_osc.fast_sel |-> o_gates.fast_osc)
        else $error("fast oscillator stopped while selected");
    a_div_gap: assert property (
        o_mode == PMC_RUN && o_sys_clk_en
        |=> ##[0:15] (o_sys_clk_en || o_mode != PMC_RUN))
        else $error("system clock enable gap above sixteen");
    a_resp_hold: assert property (
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped before acceptance");
    a_read_hold: assert property (
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped before acceptance");
endmodule

bind pmc_top pmc_top_sva i_pmc_top_sva (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_bready(i_bready),
    .i_rready(i_rready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_gates(o_gates),
    .o_osc(o_osc), .o_sys_clk_en(o_sys_clk_en), .o_mode(o_mode)
);

`default_nettype wire

// file: test/pmc_cpu_model.sv
`include "pmc_params.svh"
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Core model issuing register accesses
// ****************************************
module pmc_cpu_model (
    // Clock.
    input wire logic i_clk,
    // Requests towards the block.
    output logic o_awvalid,
    output logic [`PMC_ADDR_W-1:0] o_awaddr,
    output logic o_wvalid,
    output logic [31:0] o_wdata,
    output logic [3:0] o_wstrb,
    output logic o_bready,
    output logic o_arvalid,
    output logic [`PMC_ADDR_W-1:0] o_araddr,
    output logic o_rready,
    // Answers from the block.
    input wire logic i_awready,
    input wire logic i_wready,
    input wire logic i_bvalid,
    input wire logic [1:0] i_bresp,
    input wire logic i_arready,
    input wire logic i_rvalid,
    input wire logic [31:0] i_rdata,
    input wire logic [1:0] i_rresp
);
    // Idle bus at time zero.
    initial begin
        {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
        {o_awaddr, o_araddr, o_wdata} = 52'h0;
        o_wstrb = 4'hF;
    end

    // One access; slow delays bready or rready, released payloads invert.
    task automatic xfer(input logic we, input logic [9:0] a,
            input logic [7:0] d, input logic slow,
            output logic [31:0] rd, output logic [1:0] rs);
        bit done;
        done = 1'b0;
        rd = 32'h0;
        @(posedge i_clk);
        o_awvalid <= we;
        o_wvalid <= we;
        o_awaddr <= a;
        o_wdata <= {24'h0, d};
        o_arvalid <= !we;
        o_araddr <= a;
        o_bready <= we && !slow;
        o_rready <= !we && !slow;
        while (!done) begin
            @(posedge i_clk);
            if (o_awvalid && i_awready) begin
                o_awvalid <= 1'b0;
                o_awaddr <= ~o_awaddr;
            end
            if (o_wvalid && i_wready) begin
                o_wvalid <= 1'b0;
                o_wdata <= ~o_wdata;
            end
            if (o_arvalid && i_arready) begin
                o_arvalid <= 1'b0;
                o_araddr <= ~o_araddr;
            end
            if (o_bready && i_bvalid) begin
                rs = i_bresp;
                o_bready <= 1'b0;
                done = 1'b1;
            end else if (we && i_bvalid) begin
                o_bready <= 1'b1;
            end
            if (o_rready && i_rvalid) begin
                rd = i_rdata;
                rs = i_rresp;
                o_rready <= 1'b0;
                done = 1'b1;
            end else if (!we && i_rvalid) begin
                o_rready <= 1'b1;
            end
        end
    endtask
endmodule

`default_nettype wire

// file: test/pmc_top_bench.sv
`include "pmc_params.svh"
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Self-checking bench
// ****************************************
module pmc_top_bench;
    import pmc_pkg::*;
    localparam logic [7:0] pw = `PMC_IDX_PWR;
    localparam logic [7:0] ck = `PMC_IDX_CLK;
    localparam logic [7:0] fl = `PMC_IDX_FLAG;
    localparam logic [7:0] en = `PMC_IDX_ENA;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, sclk;
    logic [9:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [2:0] ext = 3'h7;
    logic [3:0] p1 = 4'hF;
    logic tick = 1'b0, oth = 1'b0, wdt = 1'b1, slow = 1'b0;
    pmc_gates_s gates;
    pmc_osc_s osc;
    pmc_mode_e mode;
    int n_mismatch = 0, total_checks = 0, cyc = 0;

    pmc_top i_pmc_top (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp), .i_ext_irq_pin(ext),
        .i_port1_pin(p1), .i_tick_irq(tick), .i_other_irq(oth),
        .i_wdt_en(wdt), .o_gates(gates), .o_osc(osc),
        .o_sys_clk_en(sclk), .o_mode(mode));
    pmc_cpu_model i_pmc_cpu_model (.i_clk(i_clk),
        .o_awvalid(awvalid), .o_awaddr(awaddr), .o_wvalid(wvalid),
        .o_wdata(wdata), .o_wstrb(wstrb), .o_bready(bready),
        .o_arvalid(arvalid), .o_araddr(araddr), .o_rready(rready),
        .i_awready(awready), .i_wready(wready), .i_bvalid(bvalid),
        .i_bresp(bresp), .i_arready(arready), .i_rvalid(rvalid),
        .i_rdata(rdata), .i_rresp(rresp));

    // Clock and hang guard.
    always #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task tk(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_mode(input pmc_mode_e exp);
        chk({30'h0, mode}, {30'h0, exp});
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] d);
        i_pmc_cpu_model.xfer(1'b1, {idx, 2'b00}, d, slow, rdv, rsp);
    endtask
    task chk_rd(input logic [7:0] idx, input logic [7:0] exp);
        i_pmc_cpu_model.xfer(1'b0, {idx, 2'b00}, 8'h00, slow, rdv, rsp);
        chk(rdv, {24'h0, exp});
    endtask
    task wc(input logic [7:0] d, input logic [7:0] exp);
        wr(ck, d);
        chk_rd(ck, exp);
    endtask
    task pulse(input bit t);
        if (t) tick <= 1'b1;
        else oth <= 1'b1;
        tk(1);
        tick <= 1'b0;
        oth <= 1'b0;
    endtask

    // Reset values and an unmapped place, answered slowly.
    task t_regs;
        slow = 1'b1;
        chk_rd(pw, 8'h00);
        chk_rd(ck, 8'h23);
        chk_rd(`PMC_IDX_AUX, 8'h06);
        chk_rd(8'h10, 8'h00);
        chk({30'h0, rsp}, {30'h0, `PMC_RESP_SLVERR});
        wr(8'h10, 8'hFF);
        chk({30'h0, rsp}, {30'h0, `PMC_RESP_SLVERR});
        slow = 1'b0;
    endtask
    // Guarded clock bits: refused writes keep the old value.
    task t_guard;
        wc(8'h63, 8'h63);
        wc(8'hE3, 8'h63);
        wc(8'h6B, 8'h6B);
        wc(8'h6F, 8'h6B);
        wc(8'h63, 8'h63);
        wc(8'h67, 8'h67);
        wc(8'h6F, 8'h67);
        wc(8'hE7, 8'hE7);
        wc(8'hE3, 8'hE3);
        chk({29'h0, osc}, 32'h3);
    endtask
    // Each divider code, measured as the gap between enable pulses.
    task automatic t_div;
        int k, n;
        int want [4] = '{16, 4, 2, 1};
        for (k = 0; k < 4; k++) begin
            wr(ck, {6'h38, k[1:0]});
            tk(17);
            n = 0;
            while (!sclk && n < 40) begin
                tk(1);
                n++;
            end
            n = 0;
            do begin
                tk(1);
                n++;
            end while (!sclk && n < 40);
            chk(n, want[k]);
        end
    endtask
    // Idle with and without peripheral stop.
    task t_idle;
        wr(en, 8'h08);
        wr(pw, 8'h01);
        tk(4);
        chk_mode(PMC_IDLE);
        chk({30'h0, gates.cpu, gates.periph}, 32'h1);
        pulse(0);
        tk(4);
        chk_mode(PMC_RUN);
        chk_rd(pw, 8'h00);
        wr(ck, 8'hF3);
        wr(pw, 8'h01);
        tk(4);
        chk({29'h0, gates.cpu, gates.periph, gates.tick}, 32'h1);
        pulse(1);
        tk(4);
        chk_mode(PMC_RUN);
        chk_rd(fl, 8'h10);
        wr(fl, 8'h1F);
    endtask
    // Halt: other interrupts ignored, the tick wakes.
    task t_halt;
        wdt <= 1'b0;
        wr(ck, 8'hC3);
        wr(pw, 8'h02);
        tk(4);
        chk_mode(PMC_HALT);
        chk({26'h0, gates}, 32'h09);
        pulse(0);
        tk(4);
        chk_mode(PMC_HALT);
        pulse(1);
        tk(4);
        chk_mode(PMC_RUN);
        wdt <= 1'b1;
        wr(fl, 8'h1F);
    endtask
    // Stop: the tick is ignored, a falling pin wakes.
    task t_stop;
        wr(en, 8'h02);
        wr(ck, 8'hE3);
        wr(pw, 8'h02);
        tk(4);
        chk_mode(PMC_STOP);
        chk({26'h0, gates}, 32'h04);
        pulse(1);
        tk(4);
        chk_mode(PMC_STOP);
        ext <= 3'h5;
        tk(10);
        chk_mode(PMC_RUN);
        chk_rd(pw, 8'h00);
        chk_rd(ck, 8'hE3);
        ext <= 3'h7;
        wr(fl, 8'h1F);
    endtask
    // Power-down refused while an enabled pin is held low.
    task t_refuse;
        wr(en, 8'h04);
        ext <= 3'h3;
        tk(8);
        wr(fl, 8'h1F);
        wr(pw, 8'h02);
        tk(4);
        chk_rd(pw, 8'h00);
        chk_mode(PMC_RUN);
        ext <= 3'h7;
        tk(8);
    endtask
    // Flags for a disabled ext pin and a port1 change, then a pin-change wake from stop.
    task t_port;
        wr(en, 8'h10);
        p1 <= 4'h2;
        ext <= 3'h6;
        tk(8);
        chk_rd(fl, 8'h09);
        ext <= 3'h7;
        tk(8);
        wr(fl, 8'h1F);
        wr(pw, 8'h02);
        tk(4);
        chk_mode(PMC_STOP);
        p1 <= 4'h3;
        tk(10);
        chk_mode(PMC_RUN);
    endtask

    // Main sequence.
    initial begin
        tk(3);
        i_rstn <= 1'b1;
        tk(1);
        t_regs;
        t_guard;
        t_div;
        t_idle;
        t_halt;
        t_stop;
        t_refuse;
        t_port;
        print_verdict();
    end
endmodule

`default_nettype wire
